// File: hdl/pcg_pkg.sv
// Purpose: Shared constants and types for the peripheral and USB clock gating block
// Assumes: APB with 32-bit data; printed offsets are word indices, byte address = 4 * index
// Notes:   Registers are 16 bits wide in the low half of the data word

`default_nettype none

package pcg_pkg;
	localparam int ADDR_W = 18;

	// ---------------------------------------------------------------
	// Register indices (byte address = 4 * index)
	// ---------------------------------------------------------------
	localparam logic [15:0] IDX_RTC_PM    = 16'h1930;
	localparam logic [15:0] IDX_USB_SC    = 16'h1c32;
	localparam logic [15:0] IDX_CLK_STOP  = 16'h1c3a;
	localparam logic [15:0] IDX_GATE_ONE  = 16'h1c02;
	localparam logic [15:0] IDX_GATE_TWO  = 16'h1c03;
	localparam logic [15:0] IDX_CLK_SRC   = 16'h1c20;
	localparam logic [15:0] IDX_RTC_LO    = 16'h1900;
	localparam logic [15:0] IDX_RTC_HI    = 16'h19ff;

	// ---------------------------------------------------------------
	// Field positions, masks and reset values
	// ---------------------------------------------------------------
	localparam int NUM_STOP = 3;            // External memory, USB, serial port
	localparam int STOP_USB = 1;
	localparam logic [15:0] STOP_REQ_MASK = 16'h0015;
	localparam logic [15:0] GATE_RESET    = 16'h0000;

	localparam int CS_BYPASS = 0;
	localparam int CS_SOURCE = 1;           // 0 external input, 1 RTC
	localparam int CS_PLL_PD = 2;
	localparam logic [15:0] CS_MASK  = 16'h0007;
	localparam logic [15:0] CS_RESET = 16'h0000;

	localparam int USB_PWDN = 15;
	localparam int USB_SESS = 14;
	localparam int USB_VBUS = 13;
	localparam int USB_PLLF = 12;
	localparam int USB_POL  = 6;
	localparam int USB_BIAS = 3;
	localparam int USB_OSC  = 2;
	localparam int USB_BYTE = 0;
	localparam logic [15:0] USB_MASK    = 16'hf04f;
	localparam logic [15:0] USB_RESET   = 16'ha04c;
	localparam logic [1:0]  BYTE_RSVD   = 2'h3;

	localparam int RTC_WU_OUT = 4;
	localparam int RTC_WAKEUP_PIN_DIRECTION = 3;
	localparam int RTC_CKO    = 0;
	localparam logic [15:0] RTC_MASK  = 16'h0019;
	localparam logic [15:0] RTC_RESET = 16'h0000;

	typedef enum logic [1:0] {SRC_PLL, SRC_EXT, SRC_RTC} pcg_clk_src_t;

	typedef struct packed {
		logic       powerDown;
		logic       sessionEndComparatorEn;
		logic       busVoltageDetectEn;
		logic       usbPllForceRelease;
		logic       usbLinePolarity;
		logic       usbOscBiasDisable;
		logic       usbOscDisable;
		logic [1:0] byteAccessSelect;
	} pcg_usb_ctl_t;

	typedef struct packed {
		logic out;
		logic oe;
	} pcg_od_pin_t;
endpackage : pcg_pkg

`default_nettype wire

// File: hdl/pcg_stop_ack.sv
// Purpose: Stop request / acknowledge handshake for one peripheral
// Assumes: moduleIdle comes from logic on the same clock
// Notes:   Acknowledge is sticky while the request stays high
`timescale 1ns/1ps
`default_nettype none

module pcg_stop_ack (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// Handshake
	input  wire logic stopReq,
	input  wire logic moduleIdle,
	output logic      stopAck
);
	import pcg_pkg::*;

	logic ack_reg;
	logic ack_next;

	always_comb begin
		// Idle may drop once stopped; hold the acknowledge anyway
		ack_next = stopReq & (ack_reg | moduleIdle);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= ack_next;
		end
	end

	assign stopAck = ack_reg;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	ack_needs_req_a: assert property (stopAck |-> $past(stopReq) && stopReq || $past(stopReq))
		else $error("acknowledge without request");
	ack_hold_a: assert property (stopAck && stopReq |=> stopAck)
		else $error("acknowledge dropped while request held");
	ack_fall_a: assert property (!stopReq |=> !stopAck)
		else $error("acknowledge kept after request cleared");
	ack_rise_a: assert property (stopReq && moduleIdle |=> stopAck)
		else $error("acknowledge not raised when idle");
	ack_seen_c: cover property (!stopAck ##1 stopAck ##[1:4] !stopReq ##1 !stopAck);
endmodule : pcg_stop_ack
`default_nettype wire

// File: hdl/pcg_top.sv
// Purpose: APB register file and clock gating controls for peripheral and USB domains
// Assumes: Single clock; rtcCrystalOk and wakeIn are asynchronous pins
// Notes:   Zero-wait APB slave; read data captured in the setup cycle
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module pcg_top (
	// Clock and reset
	input  wire logic                    clk,
	input  wire logic                    rst_n,
	// APB slave
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [pcg_pkg::ADDR_W-1:0] paddr,
	input  wire logic [31:0]             pwdata,
	output logic      [31:0]             prdata,
	output logic                         pready,
	output logic                         pslverr,
	// Peripheral stop handshake
	input  wire logic [pcg_pkg::NUM_STOP-1:0] moduleIdle,
	output logic      [pcg_pkg::NUM_STOP-1:0] stopReq,
	// Peripheral clock gates, one = stopped
	output logic      [15:0]             periphGateOne,
	output logic      [15:0]             periphGateTwo,
	// Clock generator
	output pcg_pkg::pcg_clk_src_t        sysClkSel,
	output logic                         pllPowerDown,
	// USB domain controls
	output pcg_pkg::pcg_usb_ctl_t        usbCtl,
	// RTC domain
	input  wire logic                    rtcCrystalOk,
	input  wire logic                    wakeIn,
	output pcg_pkg::pcg_od_pin_t         wakePin,
	output logic                         wakeSense,
	output logic                         rtcClockOutEnable
);
	import pcg_pkg::*;

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	logic [1:0] xtalSync_reg;
	logic [1:0] wakeSync_reg;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			xtalSync_reg <= 2'b00;
			wakeSync_reg <= 2'b00;
		end else begin
			xtalSync_reg <= {xtalSync_reg[0], rtcCrystalOk};
			wakeSync_reg <= {wakeSync_reg[0], wakeIn};
		end
	end

	logic rtcPresent;
	assign rtcPresent = xtalSync_reg[1];

	// ---------------------------------------------------------------
	// Address decode
	// ---------------------------------------------------------------
	logic [15:0] idx;
	logic        aligned;
	logic        inRtc;
	logic        hit;

	assign idx     = paddr[17:2];
	assign aligned = (paddr[1:0] == 2'b00);
	assign inRtc   = (idx >= IDX_RTC_LO) && (idx <= IDX_RTC_HI);

	always_comb begin
		// Whole RTC range drops away without its oscillator
		if (!aligned) begin
			hit = 1'b0;
		end else if (inRtc && !rtcPresent) begin
			hit = 1'b0;
		end else if (idx == IDX_RTC_PM) begin
			hit = 1'b1;
		end else if (idx == IDX_USB_SC) begin
			hit = 1'b1;
		end else if (idx == IDX_CLK_STOP) begin
			hit = 1'b1;
		end else if (idx == IDX_GATE_ONE) begin
			hit = 1'b1;
		end else if (idx == IDX_GATE_TWO) begin
			hit = 1'b1;
		end else if (idx == IDX_CLK_SRC) begin
			hit = 1'b1;
		end else begin
			hit = 1'b0;
		end
	end

	logic wrEn;
	assign wrEn    = psel && penable && pwrite && hit;
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !hit;

	// ---------------------------------------------------------------
	// Register state
	// ---------------------------------------------------------------
	logic [15:0] stop_reg,  stop_next;
	logic [15:0] gone_reg,  gone_next;
	logic [15:0] gtwo_reg,  gtwo_next;
	logic [15:0] csrc_reg,  csrc_next;
	logic [15:0] usb_reg,   usb_next;
	logic [15:0] rtc_reg,   rtc_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [NUM_STOP-1:0] stopAck;
	logic [15:0] stopView;

	always_comb begin
		stopView = stop_reg & STOP_REQ_MASK;
		for (int i = 0; i < NUM_STOP; i++) begin
			stopView[2*i+1] = stopAck[i];
		end
	end

	always_comb begin
		stop_next = stop_reg;
		gone_next = gone_reg;
		gtwo_next = gtwo_reg;
		csrc_next = csrc_reg;
		usb_next  = usb_reg;
		rtc_next  = rtc_reg;
		if (wrEn) begin
			if (idx == IDX_CLK_STOP) begin
				stop_next = pwdata[15:0] & STOP_REQ_MASK;
			end else if (idx == IDX_GATE_ONE) begin
				gone_next = pwdata[15:0];
			end else if (idx == IDX_GATE_TWO) begin
				gtwo_next = pwdata[15:0];
			end else if (idx == IDX_CLK_SRC) begin
				csrc_next = pwdata[15:0] & CS_MASK;
			end else if (idx == IDX_USB_SC) begin
				// Reserved bits dropped so they always read zero
				usb_next = pwdata[15:0] & USB_MASK;
				if (pwdata[USB_BYTE+1:USB_BYTE] == BYTE_RSVD) begin
					usb_next[USB_BYTE+1:USB_BYTE] = usb_reg[USB_BYTE+1:USB_BYTE];
				end
			end else if (idx == IDX_RTC_PM) begin
				rtc_next = pwdata[15:0] & RTC_MASK;
			end
		end
	end

	always_comb begin
		rdata_next = rdata_reg;
		if (psel && !penable) begin
			rdata_next = 32'h0000_0000;
			if (!hit) begin
				rdata_next = 32'h0000_0000;
			end else if (idx == IDX_CLK_STOP) begin
				rdata_next[15:0] = stopView;
			end else if (idx == IDX_GATE_ONE) begin
				rdata_next[15:0] = gone_reg;
			end else if (idx == IDX_GATE_TWO) begin
				rdata_next[15:0] = gtwo_reg;
			end else if (idx == IDX_CLK_SRC) begin
				rdata_next[15:0] = csrc_reg;
			end else if (idx == IDX_USB_SC) begin
				rdata_next[15:0] = usb_reg;
			end else if (idx == IDX_RTC_PM) begin
				rdata_next[15:0] = rtc_reg;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stop_reg  <= 16'h0000;
			gone_reg  <= GATE_RESET;
			gtwo_reg  <= GATE_RESET;
			csrc_reg  <= CS_RESET;
			usb_reg   <= USB_RESET;
			rtc_reg   <= RTC_RESET;
			rdata_reg <= 32'h0000_0000;
		end else begin
			stop_reg  <= stop_next;
			gone_reg  <= gone_next;
			gtwo_reg  <= gtwo_next;
			csrc_reg  <= csrc_next;
			usb_reg   <= usb_next;
			rtc_reg   <= rtc_next;
			rdata_reg <= rdata_next;
		end
	end

	assign prdata = rdata_reg;

	// ---------------------------------------------------------------
	// Stop handshakes, one per peripheral
	// ---------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < NUM_STOP; g++) begin : gStop
			assign stopReq[g] = stop_reg[2*g];
			pcg_stop_ack uAck (
				.clk        (clk),
				.rst_n      (rst_n),
				.stopReq    (stopReq[g]),
				.moduleIdle (moduleIdle[g]),
				.stopAck    (stopAck[g])
			);
		end
	endgenerate

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	// Gates follow the register directly, no idle instruction needed
	assign periphGateOne = gone_reg;
	assign periphGateTwo = gtwo_reg;

	always_comb begin
		if (!csrc_reg[CS_BYPASS]) begin
			sysClkSel = SRC_PLL;
		end else if (csrc_reg[CS_SOURCE]) begin
			sysClkSel = SRC_RTC;
		end else begin
			sysClkSel = SRC_EXT;
		end
	end

	// Bypass leaves the PLL running; only its own power-down stops it
	assign pllPowerDown = csrc_reg[CS_PLL_PD];

	assign usbCtl.powerDown              = usb_reg[USB_PWDN];
	assign usbCtl.sessionEndComparatorEn = usb_reg[USB_SESS];
	assign usbCtl.busVoltageDetectEn     = usb_reg[USB_VBUS];
	assign usbCtl.usbPllForceRelease     = usb_reg[USB_PLLF];
	assign usbCtl.usbLinePolarity        = usb_reg[USB_POL];
	assign usbCtl.usbOscBiasDisable      = usb_reg[USB_BIAS];
	assign usbCtl.usbOscDisable          = usb_reg[USB_OSC];
	assign usbCtl.byteAccessSelect       = usb_reg[USB_BYTE+1:USB_BYTE];

	// Open drain: only ever pulls low
	assign wakePin.out = 1'b0;
	assign wakePin.oe  = rtc_reg[RTC_WAKEUP_PIN_DIRECTION] && !rtc_reg[RTC_WU_OUT];
	assign wakeSense   = !rtc_reg[RTC_WAKEUP_PIN_DIRECTION] && wakeSync_reg[1];
	assign rtcClockOutEnable = rtc_reg[RTC_CKO];

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	gate_immediate_a: assert property (wrEn && idx == IDX_GATE_TWO |=> periphGateTwo == $past(pwdata[15:0]))
		else $error("gate two not applied on write");
	bypass_source_a: assert property (csrc_reg[CS_BYPASS] |-> sysClkSel != SRC_PLL)
		else $error("bypass still selects generator");
	bypass_pll_a: assert property (wrEn && idx == IDX_CLK_SRC && pwdata[CS_BYPASS] && !pwdata[CS_PLL_PD] |=> !pllPowerDown && sysClkSel != SRC_PLL)
		else $error("bypass stopped PLL");
	usb_power_a: assert property (wrEn && idx == IDX_USB_SC |=> usbCtl.powerDown == $past(pwdata[USB_PWDN]) && usbCtl.usbOscDisable == $past(pwdata[USB_OSC]))
		else $error("USB control field not written");
	usb_reserved_a: assert property (psel && penable && !pwrite && hit && idx == IDX_USB_SC |-> prdata[11:7] == 5'h00 && prdata[5:4] == 2'h0)
		else $error("USB reserved bits nonzero");
	byte_reserved_a: assert property (wrEn && idx == IDX_USB_SC && pwdata[1:0] == BYTE_RSVD |=> usbCtl.byteAccessSelect == $past(usbCtl.byteAccessSelect))
		else $error("reserved byte mode accepted");
	rtc_absent_a: assert property (psel && penable && aligned && inRtc && !rtcPresent |-> pslverr ##1 $stable(rtc_reg))
		else $error("RTC reached without crystal");
	wake_drive_a: assert property (wrEn && idx == IDX_RTC_PM && pwdata[RTC_WAKEUP_PIN_DIRECTION] && !pwdata[RTC_WU_OUT] |=> wakePin.oe && wakePin.out == 1'b0 && !wakeSense)
		else $error("wakeup pin not pulled low");
	wake_input_a: assert property (wrEn && idx == IDX_RTC_PM && !pwdata[RTC_WAKEUP_PIN_DIRECTION] |=> !wakePin.oe)
		else $error("wakeup input still driven");

	gate_write_c: cover property (wrEn && idx == IDX_GATE_TWO ##1 periphGateTwo != 16'h0000);
	usb_ack_c: cover property (stopReq[STOP_USB] ##[1:8] stopAck[STOP_USB]);
	bypass_rtc_c: cover property (sysClkSel == SRC_RTC);
	slverr_c: cover property (pslverr);
endmodule : pcg_top
`default_nettype wire

// File: verif/pcg_top_tb.sv
// Purpose: Self-checking bench for the peripheral and USB clock gating block
// Assumes: Zero-wait APB slave; byte address is four times the register index
// Notes:   Each scenario is a task that drives the block and judges the result
`timescale 1ns/1ps
`default_nettype none

module pcg_top_tb;
	import pcg_pkg::*;

	logic                clk;
	logic                rst_n;
	logic                psel;
	logic                penable;
	logic                pwrite;
	logic [ADDR_W-1:0]   paddr;
	logic [31:0]         pwdata;
	logic [31:0]         prdata;
	logic                pready;
	logic                pslverr;
	logic [NUM_STOP-1:0] moduleIdle;
	logic [NUM_STOP-1:0] stopReq;
	logic [15:0]         periphGateOne;
	logic [15:0]         periphGateTwo;
	pcg_clk_src_t        sysClkSel;
	logic                pllPowerDown;
	pcg_usb_ctl_t        usbCtl;
	logic                rtcCrystalOk;
	logic                wakeIn;
	pcg_od_pin_t         wakePin;
	logic                wakeSense;
	logic                rtcClockOutEnable;
	int                  failCount;
	int                  nCompared;
	logic [31:0]         rd;
	logic                err;

	// Bench's choice of gate bit; every gate bit is plain storage
	localparam logic [15:0] USB_GATE_BIT = 16'h0004;

	pcg_top pcg_top_i (
		.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .moduleIdle(moduleIdle), .stopReq(stopReq),
		.periphGateOne(periphGateOne), .periphGateTwo(periphGateTwo),
		.sysClkSel(sysClkSel), .pllPowerDown(pllPowerDown), .usbCtl(usbCtl),
		.rtcCrystalOk(rtcCrystalOk), .wakeIn(wakeIn), .wakePin(wakePin),
		.wakeSense(wakeSense), .rtcClockOutEnable(rtcClockOutEnable)
	);

	always #5 clk = ~clk;

	// ---------------------------------------------------------------
	// Bus and compare helpers
	// ---------------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		nCompared++;
		if (seen !== exp) begin
			failCount++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	// Entered right after a rising edge; leaves one idle cycle so drivers never collide
	task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= {idx, 2'h0};
		pwdata  <= wd;
		@(posedge clk);
		penable <= 1'b1;
		// Waits as long as the slave needs; only the watchdog ends a hang
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd  = prdata;
		err = pslverr;
		chk("pready", 32'(pready), 32'h1);
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb

	task automatic rchk(input logic [15:0] idx, input logic [31:0] exp, input string what);
		apb(1'b0, idx, 32'h0);
		chk(what, rd, exp);
		chk("pslverr", 32'(err), 32'h0);
	endtask : rchk

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic t_reset;
		chk("usbCtl", 32'(usbCtl), 32'h15c);
		rchk(IDX_USB_SC, 32'h0000a04c, "usb ctl");
		rchk(IDX_RTC_PM, 32'h0, "rtc pm");
		chk("oe", 32'(wakePin.oe), 32'h0);
		chk("stopReq", 32'(stopReq), 32'h0);
		chk("gates", {periphGateOne, periphGateTwo}, 32'h0);
	endtask : t_reset

	task automatic t_usb;
		logic [15:0] wd[8] = '{16'h8000, 16'h4000, 16'h2000, 16'h1000,
			16'h0040, 16'h0008, 16'h0004, 16'h0001};
		logic [8:0]  ex[8] = '{9'h100, 9'h080, 9'h040, 9'h020, 9'h010, 9'h008, 9'h004, 9'h001};
		for (int i = 0; i < 8; i++) begin
			apb(1'b1, IDX_USB_SC, {16'h0, wd[i]});
			chk("usbCtl", 32'(usbCtl), 32'(ex[i]));
			rchk(IDX_USB_SC, 32'(wd[i]), "usb ctl");
		end
		apb(1'b1, IDX_USB_SC, 32'h0000ff82);
		rchk(IDX_USB_SC, 32'h0000f002, "usb ctl");
		apb(1'b1, IDX_USB_SC, 32'h0000ffff);
		rchk(IDX_USB_SC, 32'h0000f04e, "usb ctl");
		chk("usbCtl", 32'(usbCtl), 32'h1fe);
	endtask : t_usb

	task automatic t_stop;
		for (int i = 0; i < NUM_STOP; i++) begin
			moduleIdle <= 3'(1 << i);
			@(posedge clk);
			rchk(IDX_CLK_STOP, 32'h0, "idle alone");
			moduleIdle <= 3'h0;
			apb(1'b1, IDX_CLK_STOP, 32'(1 << (2 * i)));
			chk("stopReq", 32'(stopReq), 32'(1 << i));
			rchk(IDX_CLK_STOP, 32'(1 << (2 * i)), "no ack");
			moduleIdle <= 3'(1 << i);
			@(posedge clk);
			rchk(IDX_CLK_STOP, 32'(3 << (2 * i)), "ack");
			moduleIdle <= 3'h0;
			@(posedge clk);
			rchk(IDX_CLK_STOP, 32'(3 << (2 * i)), "ack held");
			apb(1'b1, IDX_CLK_STOP, 32'h0);
			rchk(IDX_CLK_STOP, 32'h0, "ack fall");
		end
	endtask : t_stop

	// USB idle then wake, in the order software must keep
	task automatic t_usb_seq;
		apb(1'b1, IDX_USB_SC, 32'h00002048);
		chk("osc on", 32'(usbCtl.usbOscDisable), 32'h0);
		// No DMA traffic exists in this bench, so nothing is left to drain
		apb(1'b1, IDX_CLK_STOP, 32'(1 << (2 * STOP_USB)));
		moduleIdle <= 3'(1 << STOP_USB);
		do begin
			apb(1'b0, IDX_CLK_STOP, 32'h0);
		end while (rd[2 * STOP_USB + 1] !== 1'b1);
		chk("usb ack", rd, 32'(3 << (2 * STOP_USB)));
		apb(1'b1, IDX_GATE_TWO, 32'(USB_GATE_BIT));
		chk("usb gate", 32'(periphGateTwo), 32'(USB_GATE_BIT));
		apb(1'b1, IDX_USB_SC, 32'h0000204c);
		chk("osc off", 32'(usbCtl.usbOscDisable), 32'h1);
		apb(1'b1, IDX_USB_SC, 32'h00002048);
		chk("osc back", 32'(usbCtl.usbOscDisable), 32'h0);
		repeat (8) @(posedge clk);
		apb(1'b1, IDX_GATE_TWO, 32'h0);
		chk("usb ungate", 32'(periphGateTwo), 32'h0);
		rchk(IDX_CLK_STOP, 32'(3 << (2 * STOP_USB)), "ack before clear");
		apb(1'b1, IDX_CLK_STOP, 32'h0);
		moduleIdle <= 3'h0;
		rchk(IDX_CLK_STOP, 32'h0, "usb woken");
	endtask : t_usb_seq

	task automatic t_gates;
		apb(1'b1, IDX_GATE_ONE, 32'h0000a5a5);
		chk("gate one", 32'(periphGateOne), 32'h0000a5a5);
		apb(1'b1, IDX_GATE_TWO, 32'h00005a5a);
		chk("gate two", 32'(periphGateTwo), 32'h00005a5a);
		rchk(IDX_GATE_ONE, 32'h0000a5a5, "gate one rd");
		apb(1'b1, IDX_GATE_TWO, 32'h0);
		chk("gate two", 32'(periphGateTwo), 32'h0);
	endtask : t_gates

	task automatic t_src;
		logic [2:0]   wd[6] = '{3'h1, 3'h3, 3'h5, 3'h4, 3'h2, 3'h0};
		pcg_clk_src_t sl[6] = '{SRC_EXT, SRC_RTC, SRC_EXT, SRC_PLL, SRC_PLL, SRC_PLL};
		logic         pd[6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
		for (int i = 0; i < 6; i++) begin
			apb(1'b1, IDX_CLK_SRC, 32'(wd[i]));
			chk("sysClkSel", 32'(sysClkSel), 32'(sl[i]));
			chk("pllPowerDown", 32'(pllPowerDown), 32'(pd[i]));
		end
	endtask : t_src

	task automatic t_rtc;
		apb(1'b1, IDX_RTC_PM, 32'h0000ffff);
		rchk(IDX_RTC_PM, 32'h00000019, "rtc pm");
		chk("clkout", 32'(rtcClockOutEnable), 32'h1);
		chk("oe", 32'(wakePin.oe), 32'h0);
		apb(1'b1, IDX_RTC_PM, 32'h00000008);
		chk("oe out", {31'h0, wakePin.oe} | {wakePin.out, 1'b0}, 32'h1);
		wakeIn <= 1'b1;
		apb(1'b1, IDX_RTC_PM, 32'h0);
		repeat (3) @(posedge clk);
		chk("oe", 32'(wakePin.oe), 32'h0);
		chk("wakeSense", 32'(wakeSense), 32'h1);
		apb(1'b1, IDX_RTC_PM, 32'h00000018);
		chk("wakeSense", 32'(wakeSense), 32'h0);
		rtcCrystalOk <= 1'b0;
		repeat (3) @(posedge clk);
		apb(1'b1, IDX_RTC_PM, 32'h00000008);
		chk("refused", 32'(err), 32'h1);
		apb(1'b0, IDX_RTC_PM, 32'h0);
		chk("no crystal", {rd[30:0], err}, 32'h1);
		rtcCrystalOk <= 1'b1;
		repeat (3) @(posedge clk);
		rchk(IDX_RTC_PM, 32'h00000018, "rtc kept");
		apb(1'b0, 16'h1c10, 32'h0);
		chk("unmapped", 32'(err), 32'h1);
	endtask : t_rtc

	// ---------------------------------------------------------------
	// Run control
	// ---------------------------------------------------------------
	task automatic summarize;
		$display("compared %0d mismatched %0d", nCompared, failCount);
		if (failCount == 0 && nCompared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : summarize

	initial begin
		#50000;
		failCount++;
		summarize();
	end

	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = 32'h0;
		moduleIdle = 3'h0;
		rtcCrystalOk = 1'b1;
		wakeIn = 1'b0;
		failCount = 0;
		nCompared = 0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		// RTC range needs the crystal status to pass its synchroniser first
		repeat (3) @(posedge clk);
		t_reset();
		t_usb();
		t_stop();
		t_usb_seq();
		t_gates();
		t_src();
		t_rtc();
		summarize();
	end
endmodule : pcg_top_tb

`default_nettype wire
